// >>> core/xie_pkg.sv
package xie_pkg;

  // memory geometry
  localparam int          DM_AW      = 5;
  localparam int          DM_WORDS   = 32;
  localparam int          PM_AW      = 13;
  localparam int          PG_AW      = 5;
  localparam logic [4:0]  PAGE_LAST  = 5'h1F;
  localparam int          BUS_AW     = 12;

  // register byte addresses
  localparam logic [11:0] A_INSTR    = 12'h000;
  localparam logic [11:0] A_WORK     = 12'h004;
  localparam logic [11:0] A_FLAGS    = 12'h008;
  localparam logic [11:0] A_TPTR_LO  = 12'h00C;
  localparam logic [11:0] A_TPTR_HI  = 12'h010;
  localparam logic [11:0] A_TLATCH   = 12'h014;
  localparam logic [11:0] A_STAT     = 12'h018;
  localparam logic [11:0] A_PC       = 12'h01C;
  localparam logic [11:0] A_DMEM     = 12'h100;
  localparam logic [11:0] A_DMEM_END = 12'h17C;

  // reset values and bus answers
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [12:0] PC_RST     = 13'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // opcodes held in the low five bits of the instruction register
  localparam logic [4:0]  OP_SKIP_NZ = 5'h00;
  localparam logic [4:0]  OP_SUB_W   = 5'h01;
  localparam logic [4:0]  OP_SUB_M   = 5'h02;
  localparam logic [4:0]  OP_SWAP_M  = 5'h03;
  localparam logic [4:0]  OP_SWAP_W  = 5'h04;
  localparam logic [4:0]  OP_SKIP_Z  = 5'h05;
  localparam logic [4:0]  OP_MOVE_SZ = 5'h06;
  localparam logic [4:0]  OP_SKIP_BC = 5'h07;
  localparam logic [4:0]  OP_TRD_CUR = 5'h08;
  localparam logic [4:0]  OP_TRD_FIN = 5'h09;
  localparam logic [4:0]  OP_TRD_INC = 5'h0A;
  localparam logic [4:0]  OP_TRD_IFN = 5'h0B;
  localparam logic [4:0]  OP_XOR_W   = 5'h0C;
  localparam logic [4:0]  OP_XOR_M   = 5'h0D;

  typedef struct packed {
    logic sgn_carry;
    logic chain_zero;
    logic wrap;
    logic half_carry;
    logic z;
    logic c;
  } xie_flags_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] bsel;
    logic [4:0] op;
  } xie_instr_s;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY, ST_TBL} xie_state_e;

  function automatic logic is_skip(input logic [4:0] op);
    return op == OP_SKIP_NZ || op == OP_SKIP_Z || op == OP_MOVE_SZ || op == OP_SKIP_BC;
  endfunction

  function automatic logic is_table(input logic [4:0] op);
    return op == OP_TRD_CUR || op == OP_TRD_FIN || op == OP_TRD_INC || op == OP_TRD_IFN;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return a == A_INSTR || a == A_WORK || a == A_FLAGS || a == A_TPTR_LO || a == A_TPTR_HI ||
           a == A_TLATCH || a == A_STAT || a == A_PC || (a >= A_DMEM && a <= A_DMEM_END);
  endfunction

endpackage

// >>> core/xie_alu.sv
`timescale 1ns/1ps
module xie_alu (
  // operation select
  input  wire logic [4:0]          op,
  // operands and incoming flags
  input  wire logic [7:0]          acc,
  input  wire logic [7:0]          mem,
  input  wire xie_pkg::xie_flags_s flg_in,
  // results
  output logic [7:0]               res,
  output xie_pkg::xie_flags_s      flg_out,
  output logic                     wr_acc,
  output logic                     wr_mem
);

  logic [8:0] diff;
  logic [4:0] hdiff;
  logic       is_sub;
  logic       is_xor;
  logic       sub_wrap;
  xie_pkg::xie_flags_s sub_flg;

  // nine-bit subtraction so the borrow is visible
  assign diff   = {1'b0, acc} - {1'b0, mem};
  assign hdiff  = {1'b0, acc[3:0]} - {1'b0, mem[3:0]};
  assign is_sub = op == xie_pkg::OP_SUB_W || op == xie_pkg::OP_SUB_M;
  assign is_xor = op == xie_pkg::OP_XOR_W || op == xie_pkg::OP_XOR_M;
  assign sub_wrap = (acc[7] ^ mem[7]) & (acc[7] ^ diff[7]);

  // carry is set for zero or positive result, cleared when a borrow occurs
  assign sub_flg.c          = ~diff[8];
  assign sub_flg.z          = diff[7:0] == 8'h00;
  assign sub_flg.half_carry = ~hdiff[4];
  assign sub_flg.wrap       = sub_wrap;
  assign sub_flg.sgn_carry  = sub_wrap ^ diff[7];
  assign sub_flg.chain_zero = diff[7:0] == 8'h00;

  // result select
  assign res = is_sub ? diff[7:0] :
               is_xor ? (acc ^ mem) :
               (op == xie_pkg::OP_SWAP_M || op == xie_pkg::OP_SWAP_W) ? {mem[3:0], mem[7:4]} : mem;

  // flag update: subtract sets all six, xor only zero, others none
  assign flg_out = is_sub ? sub_flg :
                   is_xor ? xie_pkg::xie_flags_s'{sgn_carry: flg_in.sgn_carry, chain_zero: flg_in.chain_zero,
                                                  wrap: flg_in.wrap, half_carry: flg_in.half_carry,
                                                  z: (acc ^ mem) == 8'h00, c: flg_in.c} : flg_in;

  // destinations
  assign wr_acc = op == xie_pkg::OP_SUB_W || op == xie_pkg::OP_SWAP_W ||
                  op == xie_pkg::OP_MOVE_SZ || op == xie_pkg::OP_XOR_W;
  assign wr_mem = op == xie_pkg::OP_SUB_M || op == xie_pkg::OP_SWAP_M || op == xie_pkg::OP_XOR_M;

endmodule

// >>> core/xie_exec.sv
`timescale 1ns/1ps
module xie_exec (
  // system
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // write address channel
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  // write data channel
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // write response channel
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // read address channel
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  // read data channel
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // program memory read port, data sampled in the same cycle as the registered address
  output logic [12:0]       pm_addr,
  input  wire logic [15:0]  pm_data
);

  // core state
  xie_pkg::xie_state_e  state_r;
  xie_pkg::xie_instr_s  ir_r;
  xie_pkg::xie_flags_s  flg_r;
  logic [7:0]           acc_r;
  logic [7:0]           tptr_lo_r;
  logic [7:0]           tptr_hi_r;
  logic [7:0]           tlatch_r;
  logic [12:0]          pc_r;
  logic                 skip_r;
  logic [7:0]           dmem [xie_pkg::DM_WORDS];

  // bus holding state
  logic [11:0]          awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 aw_full_r;
  logic                 w_full_r;

  // decode wires
  logic [7:0]           mem_rd;
  logic [7:0]           alu_res;
  xie_pkg::xie_flags_s  alu_flg;
  logic                 alu_wacc;
  logic                 alu_wmem;
  logic                 exec_go;
  logic                 squash;
  logic                 skip_hit;
  logic                 is_inc;
  logic [7:0]           tptr;
  logic [4:0]           tpage;
  logic                 busy;
  logic                 wr_commit;
  logic                 wr_ok;
  logic                 wr_hit;
  logic                 issue;
  logic                 dm_we;
  logic [4:0]           dm_wa;
  logic [7:0]           dm_wd;
  logic [7:0]           rd_byte;
  logic [31:0]          rd_word;
  logic                 rd_take;
  logic [4:0]           cur_op;

  xie_alu u_alu (
    .op      (ir_r.op),
    .acc     (acc_r),
    .mem     (mem_rd),
    .flg_in  (flg_r),
    .res     (alu_res),
    .flg_out (alu_flg),
    .wr_acc  (alu_wacc),
    .wr_mem  (alu_wmem)
  );

  // operand fetch and execute qualifiers
  assign cur_op  = ir_r.op;
  assign mem_rd  = dmem[ir_r.addr[xie_pkg::DM_AW-1:0]];
  assign busy    = state_r != xie_pkg::ST_IDLE;
  assign exec_go = ce && state_r == xie_pkg::ST_EXEC && !skip_r;
  assign squash  = ce && state_r == xie_pkg::ST_EXEC && skip_r;

  // skip conditions of the four conditional tests
  assign skip_hit = (cur_op == xie_pkg::OP_SKIP_NZ && mem_rd != 8'h00) ||
                    (cur_op == xie_pkg::OP_SKIP_Z && mem_rd == 8'h00) ||
                    (cur_op == xie_pkg::OP_MOVE_SZ && mem_rd == 8'h00) ||
                    (cur_op == xie_pkg::OP_SKIP_BC && !mem_rd[ir_r.bsel]);

  // table address: page from counter, high pointer or last page
  assign is_inc = cur_op == xie_pkg::OP_TRD_INC || cur_op == xie_pkg::OP_TRD_IFN;
  assign tptr   = is_inc ? tptr_lo_r + 8'h01 : tptr_lo_r;
  assign tpage  = cur_op == xie_pkg::OP_TRD_CUR ? pc_r[12:8] :
                  cur_op == xie_pkg::OP_TRD_INC ? tptr_hi_r[xie_pkg::PG_AW-1:0] :
                  xie_pkg::PAGE_LAST;

  // bus write commit: both halves held and no answer pending
  assign wr_commit = ce && aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_hit    = xie_pkg::is_mapped(awaddr_r);
  assign wr_ok     = wr_hit && !busy;
  assign issue     = wr_commit && wr_ok && awaddr_r == xie_pkg::A_INSTR && wstrb_r[1:0] == 2'h3;

  // single data memory write port: execution or bus, never both
  assign dm_we = (exec_go && alu_wmem) || (ce && state_r == xie_pkg::ST_TBL) ||
                 (wr_commit && wr_ok && awaddr_r >= xie_pkg::A_DMEM && wstrb_r[0]);
  assign dm_wa = busy ? ir_r.addr[xie_pkg::DM_AW-1:0] : awaddr_r[xie_pkg::DM_AW+1:2];
  assign dm_wd = state_r == xie_pkg::ST_TBL ? pm_data[7:0] :
                 busy ? alu_res : wdata_r[7:0];

  // read decode
  assign rd_byte = s_axi_araddr == xie_pkg::A_WORK  ? acc_r :
                   s_axi_araddr == xie_pkg::A_FLAGS ? {2'h0, flg_r} :
                   s_axi_araddr == xie_pkg::A_TPTR_LO ? tptr_lo_r :
                   s_axi_araddr == xie_pkg::A_TPTR_HI ? tptr_hi_r :
                   s_axi_araddr == xie_pkg::A_TLATCH  ? tlatch_r :
                   s_axi_araddr == xie_pkg::A_STAT  ? {6'h00, skip_r, busy} :
                   s_axi_araddr >= xie_pkg::A_DMEM  ? dmem[s_axi_araddr[xie_pkg::DM_AW+1:2]] : 8'h00;
  assign rd_word = s_axi_araddr == xie_pkg::A_INSTR ? {16'h0000, ir_r} :
                   s_axi_araddr == xie_pkg::A_PC ? {19'h00000, pc_r} : {24'h000000, rd_byte};
  assign rd_take = ce && s_axi_arvalid && s_axi_arready;

  // sequencer: issue, execute, dummy cycle of a skip, table fetch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= xie_pkg::ST_IDLE;
    end else if (ce) begin
      unique case (state_r)
        xie_pkg::ST_IDLE:  state_r <= issue ? xie_pkg::ST_EXEC : xie_pkg::ST_IDLE;
        xie_pkg::ST_EXEC: begin
          if (skip_r) begin
            state_r <= xie_pkg::ST_IDLE;
          end else if (xie_pkg::is_skip(cur_op)) begin
            state_r <= xie_pkg::ST_DUMMY;
          end else if (xie_pkg::is_table(cur_op)) begin
            state_r <= xie_pkg::ST_TBL;
          end else begin
            state_r <= xie_pkg::ST_IDLE;
          end
        end
        xie_pkg::ST_DUMMY: state_r <= xie_pkg::ST_IDLE;
        xie_pkg::ST_TBL:   state_r <= xie_pkg::ST_IDLE;
      endcase
    end
  end

  // instruction register and pending skip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_r   <= '0;
      skip_r <= 1'b0;
    end else if (ce) begin
      if (issue) begin
        ir_r <= wdata_r[15:0];
      end
      if (squash) begin
        skip_r <= 1'b0;
      end else if (exec_go && xie_pkg::is_skip(cur_op)) begin
        skip_r <= skip_hit;
      end
    end
  end

  // counter advances once per instruction, squashed ones included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= xie_pkg::PC_RST;
    end else if (ce && (squash || state_r == xie_pkg::ST_DUMMY || state_r == xie_pkg::ST_TBL ||
                        (exec_go && !xie_pkg::is_skip(cur_op) && !xie_pkg::is_table(cur_op)))) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  // work register and flags; a squashed slot leaves both alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= xie_pkg::BYTE_RST;
      flg_r <= '0;
    end else if (ce) begin
      if (exec_go && alu_wacc) begin
        acc_r <= alu_res;
      end else if (wr_commit && wr_ok && awaddr_r == xie_pkg::A_WORK && wstrb_r[0]) begin
        acc_r <= wdata_r[7:0];
      end
      if (exec_go) begin
        flg_r <= alu_flg;
      end else if (wr_commit && wr_ok && awaddr_r == xie_pkg::A_FLAGS && wstrb_r[0]) begin
        flg_r <= wdata_r[5:0];
      end
    end
  end

  // table pointers, latch and program memory address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tptr_lo_r <= xie_pkg::BYTE_RST;
      tptr_hi_r <= xie_pkg::BYTE_RST;
      tlatch_r  <= xie_pkg::BYTE_RST;
      pm_addr   <= xie_pkg::PC_RST;
    end else if (ce) begin
      if (exec_go && xie_pkg::is_table(cur_op)) begin
        tptr_lo_r <= tptr;
        pm_addr   <= {tpage, tptr};
      end else if (wr_commit && wr_ok && awaddr_r == xie_pkg::A_TPTR_LO && wstrb_r[0]) begin
        tptr_lo_r <= wdata_r[7:0];
      end
      if (wr_commit && wr_ok && awaddr_r == xie_pkg::A_TPTR_HI && wstrb_r[0]) begin
        tptr_hi_r <= wdata_r[7:0];
      end
      if (state_r == xie_pkg::ST_TBL) begin
        tlatch_r <= pm_data[15:8];
      end
    end
  end

  // data memory store, no reset on the array
  always_ff @(posedge aclk) begin
    if (dm_we) begin
      dmem[dm_wa] <= dm_wd;
    end
  end

  // write address and data taken in either order, answered once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= xie_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= {s_axi_awaddr[11:2], 2'h0};
        aw_full_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_full_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_commit) begin
        aw_full_r     <= 1'b0;
        w_full_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_ok ? xie_pkg::RESP_OKAY : xie_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one beat answered the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= xie_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= xie_pkg::is_mapped({s_axi_araddr[11:2], 2'h0}) ? rd_word : 32'h00000000;
        s_axi_rresp   <= xie_pkg::is_mapped({s_axi_araddr[11:2], 2'h0}) ? xie_pkg::RESP_OKAY
                                                                          : xie_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // checks next to the execution logic
  property p_nz_skip;
    @(posedge aclk) disable iff (!aresetn)
      exec_go && cur_op == xie_pkg::OP_SKIP_NZ |=> skip_r == ($past(mem_rd) != 8'h00) && flg_r == $past(flg_r);
  endproperty
  a_nz_skip: assert property (p_nz_skip) else $error("nonzero skip decision wrong");

  property p_sub_carry;
    @(posedge aclk) disable iff (!aresetn)
      exec_go && cur_op == xie_pkg::OP_SUB_W |=> flg_r.c == ($past(acc_r) >= $past(mem_rd)) &&
                                                 flg_r.z == (acc_r == 8'h00);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry or zero wrong");

  property p_subm_store;
    @(posedge aclk) disable iff (!aresetn)
      exec_go && cur_op == xie_pkg::OP_SUB_M |-> dm_we && dm_wd == mem_rd - mem_rd + acc_r - mem_rd;
  endproperty
  a_subm_store: assert property (p_subm_store) else $error("subtract to memory store wrong");

  property p_swap_keep;
    @(posedge aclk) disable iff (!aresetn)
      exec_go && cur_op == xie_pkg::OP_SWAP_M |-> dm_wd == {mem_rd[3:0], mem_rd[7:4]} ##1 $stable(flg_r);
  endproperty
  a_swap_keep: assert property (p_swap_keep) else $error("nibble exchange wrong");

  property p_swapa;
    @(posedge aclk) disable iff (!aresetn)
      exec_go && cur_op == xie_pkg::OP_SWAP_W |-> !dm_we ##1 acc_r[3:0] == $past(mem_rd[7:4]) &&
                                                            acc_r[7:4] == $past(mem_rd[3:0]);
  endproperty
  a_swapa: assert property (p_swapa) else $error("nibble exchange to work wrong");

  property p_skip_two;
    @(posedge aclk) disable iff (!aresetn || !ce)
      exec_go && xie_pkg::is_skip(cur_op) |=> state_r == xie_pkg::ST_DUMMY ##1 state_r == xie_pkg::ST_IDLE;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip did not take two cycles");

  property p_squash;
    @(posedge aclk) disable iff (!aresetn)
      squash |-> !dm_we ##1 $stable(acc_r) && $stable(flg_r) && !skip_r && pc_r == $past(pc_r) + 13'h0001;
  endproperty
  a_squash: assert property (p_squash) else $error("skipped instruction not squashed");

  property p_tbl_cur;
    @(posedge aclk) disable iff (!aresetn)
      exec_go && cur_op == xie_pkg::OP_TRD_CUR |=> pm_addr == {$past(pc_r[12:8]), $past(tptr_lo_r)} &&
                                                   $stable(tptr_lo_r);
  endproperty
  a_tbl_cur: assert property (p_tbl_cur) else $error("current page table address wrong");

  property p_tbl_flags;
    @(posedge aclk) disable iff (!aresetn)
      ce && state_r == xie_pkg::ST_TBL |=> $stable(flg_r) && tlatch_r == $past(pm_data[15:8]);
  endproperty
  a_tbl_flags: assert property (p_tbl_flags) else $error("table read touched flags or latch wrong");

endmodule

// >>> tb/xie_pmem.sv
`timescale 1ns/1ps
// program memory model: asynchronous word read with a pattern derived from the address
module xie_pmem (
  // read port
  input  wire logic [12:0] pm_addr,
  output logic [15:0]      pm_data
);
  // high byte carries the page, low byte the inverted offset
  assign pm_data = {3'h5, pm_addr[12:8], ~pm_addr[7:0]};
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
// register-bus bench for the execution block
module testbench;
  // bus and program memory wiring
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        awr, wrd, bv, arr, rv;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h00000000, rdat, v;
  logic [1:0]  bresp, rresp, resp;
  logic [12:0] pma, p, pa;
  logic [15:0] pmd, pw;
  logic [7:0]  sa [3] = '{8'h10, 8'h80, 8'h35};
  logic [7:0]  sm [3] = '{8'h20, 8'h01, 8'h35};
  logic [16:0] skt [8] = '{{5'h00, 8'h00, 3'h0, 1'b0}, {5'h00, 8'h40, 3'h0, 1'b1}, {5'h05, 8'h00, 3'h0, 1'b1},
                           {5'h05, 8'h01, 3'h0, 1'b0}, {5'h06, 8'h00, 3'h0, 1'b1}, {5'h06, 8'h9C, 3'h0, 1'b0},
                           {5'h07, 8'hF7, 3'h3, 1'b1}, {5'h07, 8'h08, 3'h3, 1'b0}};
  logic [7:0]  m, e;
  int          failures = 0, cmp_count = 0;

  // 50 ns clock
  always #25 aclk = ~aclk;

  xie_exec dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .pm_addr(pma), .pm_data(pmd));
  xie_pmem pmem (.pm_addr(pma), .pm_data(pmd));

  // comparison and verdict
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // bus write and read, each channel held until its own handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    resp = rresp;
    v = rdat;
  endtask

  // issue one instruction and wait until the block is idle
  task automatic run(input logic [7:0] ad, input logic [2:0] b, input logic [4:0] op);
    wr(xie_pkg::A_INSTR, {16'h0000, ad, b, op});
    for (int i = 0; i < 20; i++) begin
      rd(xie_pkg::A_STAT);
      if (v[0] === 1'b0) break;
    end
  endtask
  function automatic logic [11:0] da(input logic [4:0] i);
    return xie_pkg::A_DMEM + {5'h00, i, 2'h0};
  endfunction
  function automatic logic [31:0] subf(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic       o;
    r = a - b;
    o = (a[7] ^ b[7]) & (r[7] ^ a[7]);
    return {26'h0, o ^ r[7], r == 8'h00, o, a[3:0] >= b[3:0], r == 8'h00, a >= b};
  endfunction

  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    conclude();
  end

  // test sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(xie_pkg::A_WORK);
    chk("work_reset", 32'h00000000, v);
    rd(12'h0F0);
    chk("unmapped_resp", {30'h0, xie_pkg::RESP_SLVERR}, {30'h0, resp});
    for (int k = 0; k < 3; k++) begin
      wr(xie_pkg::A_WORK, {24'h0, sa[k]});
      chk("wr_resp", {30'h0, xie_pkg::RESP_OKAY}, {30'h0, resp});
      wr(da(3), {24'h0, sm[k]});
      run(8'h03, 3'h0, xie_pkg::OP_SUB_W);
      rd(xie_pkg::A_WORK);
      chk("sub_work", {24'h0, sa[k] - sm[k]}, v);
      rd(xie_pkg::A_FLAGS);
      chk("sub_flags", subf(sa[k], sm[k]), v);
      // work now holds the difference, so load the minuend again
      wr(xie_pkg::A_WORK, {24'h0, sa[k]});
      wr(da(4), {24'h0, sm[k]});
      run(8'h04, 3'h0, xie_pkg::OP_SUB_M);
      rd(da(4));
      chk("subm_mem", {24'h0, sa[k] - sm[k]}, v);
      rd(xie_pkg::A_FLAGS);
      chk("subm_flags", subf(sa[k], sm[k]), v);
    end
    wr(xie_pkg::A_FLAGS, 32'h00000015);
    wr(da(5), 32'h000000A7);
    run(8'h05, 3'h0, xie_pkg::OP_SWAP_W);
    rd(xie_pkg::A_WORK);
    chk("swapw_work", 32'h0000007A, v);
    rd(da(5));
    chk("swapw_mem", 32'h000000A7, v);
    run(8'h05, 3'h0, xie_pkg::OP_SWAP_M);
    rd(da(5));
    chk("swapm_mem", 32'h0000007A, v);
    rd(xie_pkg::A_FLAGS);
    chk("swap_flags", 32'h00000015, v);
    wr(da(6), 32'h0000007A);
    run(8'h06, 3'h0, xie_pkg::OP_XOR_W);
    rd(xie_pkg::A_FLAGS);
    chk("xorw_flags", 32'h00000017, v);
    wr(xie_pkg::A_WORK, 32'h0000000F);
    run(8'h06, 3'h0, xie_pkg::OP_XOR_M);
    rd(da(6));
    chk("xorm_mem", 32'h00000075, v);
    rd(xie_pkg::A_FLAGS);
    chk("xorm_flags", 32'h00000015, v);
    // each skip kind, taken and not taken, then a following nibble swap to work
    for (int k = 0; k < 8; k++) begin
      m = skt[k][11:4];
      wr(da(7), {24'h0, m});
      wr(xie_pkg::A_WORK, 32'h00000011);
      rd(xie_pkg::A_PC);
      p = v[12:0];
      run(8'h07, skt[k][3:1], skt[k][16:12]);
      rd(xie_pkg::A_STAT);
      chk("skip_pending", {31'h0, skt[k][0]}, {31'h0, v[1]});
      run(8'h07, 3'h0, xie_pkg::OP_SWAP_W);
      e = skt[k][0] ? 8'h11 : {m[3:0], m[7:4]};
      if (skt[k][16:12] == 5'h06) e = skt[k][0] ? m : {m[3:0], m[7:4]};
      rd(xie_pkg::A_WORK);
      chk("skip_work", {24'h0, e}, v);
      rd(xie_pkg::A_PC);
      chk("skip_pc", {19'h0, p + 13'h0002}, {19'h0, v[12:0]});
    end
    // all four table reads, pointer low at its top value
    for (int k = 0; k < 4; k++) begin
      wr(xie_pkg::A_TPTR_LO, 32'h000000FF);
      wr(xie_pkg::A_TPTR_HI, 32'h0000000A);
      rd(xie_pkg::A_PC);
      p = v[12:0];
      run(8'h08, 3'h0, 5'h08 + 5'(k));
      pa = k == 0 ? {p[12:8], 8'hFF} : k == 1 ? {xie_pkg::PAGE_LAST, 8'hFF} :
           k == 2 ? {5'h0A, 8'h00} : {xie_pkg::PAGE_LAST, 8'h00};
      pw = {3'h5, pa[12:8], ~pa[7:0]};
      rd(da(8));
      chk("tbl_mem", {24'h0, pw[7:0]}, v);
      rd(xie_pkg::A_TLATCH);
      chk("tbl_latch", {24'h0, pw[15:8]}, v);
      rd(xie_pkg::A_TPTR_LO);
      chk("tbl_ptr", k < 2 ? 32'h000000FF : 32'h00000000, v);
      rd(xie_pkg::A_FLAGS);
      chk("tbl_flags", 32'h00000015, v);
    end
    conclude();
  end
endmodule
